// ---- output_terminal_function_select.sv ----
// output_terminal_function_select.sv: apb-programmed selector for two drive output terminals,
// plus the ready and running status flags.
// assumes status sources are synchronous to pclk; start and stop pins are asynchronous.
`default_nettype none
`include "outsel_consts.svh"
module output_terminal_function_select #(
    parameter int POLE_CYCLES = (`CLK_HZ / 1000) * `POLE_DETECT_MS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // start and stop pins
    input wire logic forward_start_cmd,
    input wire logic reverse_start_cmd,
    input wire logic output_stop_input,
    // drive state from control logic
    input wire logic [15:0] output_freq,
    input wire logic init_done,
    input wire logic dc_brake_active,
    input wire logic trip_shutoff,
    input wire logic power_loss,
    // routable status sources
    input wire logic magnet_motor_mode_flag,
    input wire logic retry_active_flag,
    input wire logic pid_pause_flag,
    input wire logic energy_pulse_out,
    input wire logic wear_alarm_flag,
    input wire logic hard_fault_flag,
    input wire logic saving_update_toggle,
    input wire logic current_avg_pulse_out,
    input wire logic service_due_flag,
    input wire logic warning_flag,
    input wire logic fault_flag,
    // terminals, high = conducting / relay energised
    output logic term_a_out,
    output logic term_b_out,
    // status flags
    output logic drive_ready_flag,
    output logic running_flag
);
    localparam logic [20:0] POLE_LAST = 21'(POLE_CYCLES);

    logic [2:0] pins_sync;
    logic fwd_s;
    logic rev_s;
    logic stop_s;
    logic start_any;

    logic [7:0] term_a_select_ff;
    logic [7:0] term_b_select_ff;
    logic host_set_output_ff;
    logic [15:0] start_freq_threshold_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [20:0] pole_cnt_ff;
    logic [20:0] nxt_pole_cnt;
    logic ready_ff;
    logic running_ff;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({output_stop_input, reverse_start_cmd, forward_start_cmd}),
        .sync_out(pins_sync)
    );
    assign fwd_s = pins_sync[0];
    assign rev_s = pins_sync[1];
    assign stop_s = pins_sync[2];
    assign start_any = fwd_s | rev_s;

    // ---- apb decode
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready_ff;
    wire hit_a = (paddr == `OFS_TERM_A_SEL);
    wire hit_b = (paddr == `OFS_TERM_B_SEL);
    wire hit_host = (paddr == `OFS_HOST_OUT);
    wire hit_freq = (paddr == `OFS_START_FREQ);
    wire hit_stat = (paddr == `OFS_STATUS);
    wire mapped = hit_a | hit_b | hit_host | hit_freq | hit_stat;
    // codes above the negative range, and the saving toggle and current pulse codes on the relay, are refused
    wire code_ok = (pwdata[31:8] == 24'h0000_00) && (pwdata[7:0] <= `CODE_MAX);
    wire relay_bad = (pwdata[7:0] == `CODE_SAVING_TOGGLE) || (pwdata[7:0] == `CODE_CURRENT_PULSE)
        || (pwdata[7:0] == (`CODE_SAVING_TOGGLE + `CODE_NEG_BASE))
        || (pwdata[7:0] == (`CODE_CURRENT_PULSE + `CODE_NEG_BASE));
    wire bad_write = pwrite & (((hit_a | hit_b) & ~code_ok) | (hit_b & relay_bad) | hit_stat);
    wire nxt_err = ~mapped | bad_write;
    wire wr_ok = access_done & pwrite & ~pslverr_ff;

    wire [31:0] status_word = {25'h000_0000, stop_s, rev_s, fwd_s, term_b_out, term_a_out,
        running_ff, ready_ff};
    wire [31:0] nxt_prdata = hit_a ? {24'h0000_00, term_a_select_ff}
        : hit_b ? {24'h0000_00, term_b_select_ff}
        : hit_host ? {31'h0000_0000, host_set_output_ff}
        : hit_freq ? {16'h0000, start_freq_threshold_ff}
        : hit_stat ? status_word
        : 32'h0000_0000;

    // ready one cycle after setup: zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase & nxt_err;
            prdata_ff <= (setup_phase & ~pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end

    // per-terminal selection, host output and start frequency registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_a_select_ff <= `RST_TERM_A_SEL;
            term_b_select_ff <= `RST_TERM_B_SEL;
            host_set_output_ff <= 1'b0;
            start_freq_threshold_ff <= `RST_START_FREQ;
        end else if (wr_ok) begin
            if (hit_a) begin
                term_a_select_ff <= pwdata[7:0];
            end
            if (hit_b) begin
                term_b_select_ff <= pwdata[7:0];
            end
            if (hit_host) begin
                host_set_output_ff <= pwdata[0];
            end
            if (hit_freq) begin
                start_freq_threshold_ff <= pwdata[15:0];
            end
        end
    end

    // ---- ready and running
    wire shutoff = trip_shutoff | fault_flag | stop_s;
    wire [15:0] thr = magnet_motor_mode_flag ? `MAGNET_START_FREQ : start_freq_threshold_ff;
    wire pole_done = ~magnet_motor_mode_flag | (pole_cnt_ff == POLE_LAST);
    wire nxt_ready = init_done & ~shutoff & ~(power_loss & ~start_any);
    wire nxt_running = (output_freq >= thr) & pole_done & ~dc_brake_active & ~shutoff;

    // pole detection timer held at zero while no start command is present, counts up to POLE_LAST while one is
    always_comb begin
        nxt_pole_cnt = pole_cnt_ff;
        if (!start_any) begin
            nxt_pole_cnt = 21'h00_0000;
        end else if (pole_cnt_ff != POLE_LAST) begin
            nxt_pole_cnt = pole_cnt_ff + 21'h00_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pole_cnt_ff <= 21'h00_0000;
            ready_ff <= 1'b0;
            running_ff <= 1'b0;
        end else begin
            pole_cnt_ff <= nxt_pole_cnt;
            ready_ff <= nxt_ready;
            running_ff <= nxt_running;
        end
    end

    // terminal routing, each terminal independent
    logic [outsel_pkg::NUM_FUNC-1:0] flags;
    always_comb begin
        flags = '0;
        flags[outsel_pkg::F_RUNNING] = running_ff;
        flags[outsel_pkg::F_READY] = ready_ff;
        flags[outsel_pkg::F_MAGNET] = magnet_motor_mode_flag;
        flags[outsel_pkg::F_RETRY] = retry_active_flag;
        flags[outsel_pkg::F_PID_PAUSE] = pid_pause_flag;
        flags[outsel_pkg::F_ENERGY_PULSE] = energy_pulse_out;
        flags[outsel_pkg::F_WEAR] = wear_alarm_flag;
        flags[outsel_pkg::F_HARD_FAULT] = hard_fault_flag;
        flags[outsel_pkg::F_SAVING_TOGGLE] = saving_update_toggle;
        flags[outsel_pkg::F_CURRENT_PULSE] = current_avg_pulse_out;
        flags[outsel_pkg::F_SERVICE_DUE] = service_due_flag;
        flags[outsel_pkg::F_HOST_SET] = host_set_output_ff;
        flags[outsel_pkg::F_WARNING] = warning_flag;
        flags[outsel_pkg::F_FAULT] = fault_flag;
    end

    term_mux #(
        .IS_RELAY(1'b0)
    ) u_term_a (
        .pclk(pclk),
        .presetn(presetn),
        .sel_code(term_a_select_ff),
        .flags(flags),
        .term_out(term_a_out)
    );

    term_mux #(
        .IS_RELAY(1'b1)
    ) u_term_b (
        .pclk(pclk),
        .presetn(presetn),
        .sel_code(term_b_select_ff),
        .flags(flags),
        .term_out(term_b_out)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign drive_ready_flag = ready_ff;
    assign running_flag = running_ff;
endmodule : output_terminal_function_select
`default_nettype wire

// ---- output_terminal_function_select_bench.sv ----
// output_terminal_function_select_bench.sv: self-checking bench for the terminal selector.
// assumes the design, the checker and terminal_load are compiled first.
`default_nettype none
module output_terminal_function_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] code; logic b_err;} row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, e;
    logic fwd, rev, stop, dc_brake, trip, ploss, term_a, term_b, ready, running, a_line, b_contact;
    logic [7:0] paddr, code;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] freq;
    logic [13:0] src;
    int failures, checks, cycles;
    row_t rows [14] = '{{8'h00, 1'b0}, {8'h0B, 1'b0}, {8'h39, 1'b0}, {8'h40, 1'b0},
        {8'h46, 1'b0}, {8'h4F, 1'b0}, {8'h5A, 1'b0}, {8'h5B, 1'b0},
        {8'h5C, 1'b1}, {8'h5D, 1'b1}, {8'h5F, 1'b0}, {8'h60, 1'b0},
        {8'h62, 1'b0}, {8'h63, 1'b0}};
    // fwd, stop, brake, trip, loss, freq high, then ready and running expected
    logic [7:0] steps [8] = '{8'h07, 8'h26, 8'h02, 8'h44, 8'h14, 8'h08, 8'h8A, 8'h87};
    output_terminal_function_select #(.POLE_CYCLES(20)) i_output_terminal_function_select (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .forward_start_cmd(fwd), .reverse_start_cmd(rev), .output_stop_input(stop), .output_freq(freq),
        .init_done(src[1]), .dc_brake_active(dc_brake), .trip_shutoff(trip), .power_loss(ploss),
        .magnet_motor_mode_flag(src[2]), .retry_active_flag(src[3]), .pid_pause_flag(src[4]),
        .energy_pulse_out(src[5]), .wear_alarm_flag(src[6]), .hard_fault_flag(src[7]),
        .saving_update_toggle(src[8]), .current_avg_pulse_out(src[9]), .service_due_flag(src[10]),
        .warning_flag(src[12]), .fault_flag(src[13]), .term_a_out(term_a), .term_b_out(term_b),
        .drive_ready_flag(ready), .running_flag(running));
    terminal_load i_terminal_load (.term_a_out(term_a), .term_b_out(term_b), .a_line(a_line),
        .b_contact(b_contact));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        {psel, penable, pwrite, fwd, rev, stop, dc_brake, trip, ploss} = '0;
        paddr = '0;
        pwdata = '0;
        freq = '0;
        src = '0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, '0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h04, '0);
        chk(rd, 32'h0000_0063);
        freq <= 16'h03E8;
        repeat (6) @(posedge pclk);
        chk(a_line, 1'b0);
        foreach (rows[i]) for (int neg = 0; neg < 2; neg++) for (int v = 0; v < 2; v++) begin
            code = rows[i].code + (neg == 1 ? 8'h64 : 8'h00);
            e = v[0] ^ neg[0];
            apb(1'b1, 8'h00, {24'h00_0000, code});
            chk(err, 1'b0);
            apb(1'b1, 8'h04, {24'h00_0000, code});
            chk(err, rows[i].b_err);
            apb(1'b1, 8'h08, {31'h0000_0000, v == 1 && i == 11});
            src <= v == 1 ? 14'h0001 << i : 14'h0000;
            freq <= (v == 1 && i == 0) ? 16'h03E8 : 16'h0000;
            repeat (6) @(posedge pclk);
            chk(term_a, e);
            chk(a_line, !e);
            if (!rows[i].b_err)
                chk(b_contact, e);
        end
        src <= 14'h3FFF;
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, 8'h00, j == 1 ? 32'h0000_0065 : 32'h0000_0001);
            repeat (6) @(posedge pclk);
            chk(term_a, 1'b0);
        end
        apb(1'b1, 8'h00, 32'h0000_00FF);
        chk(err, 1'b1);
        apb(1'b0, 8'h20, '0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        src <= 14'h0002;
        foreach (steps[k]) begin
            {fwd, stop, dc_brake, trip, ploss} <= steps[k][7:3];
            freq <= steps[k][2] ? 16'h03E8 : 16'h0000;
            repeat (6) @(posedge pclk);
            chk(ready, steps[k][1]);
            chk(running, steps[k][0]);
        end
        apb(1'b1, 8'h0C, 32'h0000_0400);
        chk(err, 1'b0);
        fwd <= 1'b0;
        rev <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(running, 1'b0);
        apb(1'b0, 8'h10, '0);
        chk(rd, 32'h0000_0029);
        apb(1'b1, 8'h10, 32'h0000_0000);
        chk(err, 1'b1);
        freq <= 16'h0400;
        repeat (6) @(posedge pclk);
        chk(running, 1'b1);
        apb(1'b0, 8'h0C, '0);
        chk(rd, 32'h0000_0400);
        rev <= 1'b0;
        fwd <= 1'b0;
        src <= 14'h0006;
        freq <= 16'h0001;
        repeat (6) @(posedge pclk);
        chk(running, 1'b0);
        fwd <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(running, 1'b0);
        repeat (20) @(posedge pclk);
        chk(running, 1'b1);
        freq <= 16'h0000;
        repeat (6) @(posedge pclk);
        chk(running, 1'b0);
        // mid-run reset: outputs drop, registers return to defaults
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(term_b, 1'b0);
        chk(ready, 1'b0);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, '0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h0C, '0);
        chk(rd, 32'h0000_01F4);
        print_verdict();
    end
endmodule : output_terminal_function_select_bench
`default_nettype wire

// ---- outsel_consts.svh ----
// outsel_consts.svh: offsets, reset values, selection codes and timing for the output terminal selector.
// assumes inclusion by bare name from each design file that needs it.
`ifndef OUTSEL_CONSTS_SVH
`define OUTSEL_CONSTS_SVH

// apb byte addresses
`define OFS_TERM_A_SEL 8'h00
`define OFS_TERM_B_SEL 8'h04
`define OFS_HOST_OUT 8'h08
`define OFS_START_FREQ 8'h0C
`define OFS_STATUS 8'h10

// reset values
`define RST_TERM_A_SEL 8'h00
`define RST_TERM_B_SEL 8'h63
`define RST_START_FREQ 16'h01F4

// selection codes, positive range; negative range adds the offset
`define CODE_NEG_BASE 8'h64
`define CODE_MAX 8'hC7
`define CODE_RUNNING 8'h00
`define CODE_READY 8'h0B
`define CODE_MAGNET 8'h39
`define CODE_RETRY 8'h40
`define CODE_PID_PAUSE 8'h46
`define CODE_ENERGY_PULSE 8'h4F
`define CODE_WEAR 8'h5A
`define CODE_HARD_FAULT 8'h5B
`define CODE_SAVING_TOGGLE 8'h5C
`define CODE_CURRENT_PULSE 8'h5D
`define CODE_SERVICE_DUE 8'h5F
`define CODE_HOST_SET 8'h60
`define CODE_WARNING 8'h62
`define CODE_FAULT 8'h63

// frequency in 0.01 Hz units; threshold used under magnet motor control
`define MAGNET_START_FREQ 16'h0001

// pole detection delay
`define CLK_HZ 20_000_000
`define POLE_DETECT_MS 100

// status register bit positions
`define ST_READY 0
`define ST_RUNNING 1
`define ST_TERM_A 2
`define ST_TERM_B 3
`define ST_FWD 4
`define ST_REV 5
`define ST_STOP 6

`endif

// ---- outsel_pkg.sv ----
// outsel_pkg.sv: types shared by the output terminal selector modules.
// assumes outsel_consts.svh supplies the numeric constants.
`default_nettype none
package outsel_pkg;
    typedef logic [7:0] sel_code_t;
    // index of each routable status signal in the flag vector
    typedef enum logic [3:0] {
        F_RUNNING = 4'h0,
        F_READY = 4'h1,
        F_MAGNET = 4'h2,
        F_RETRY = 4'h3,
        F_PID_PAUSE = 4'h4,
        F_ENERGY_PULSE = 4'h5,
        F_WEAR = 4'h6,
        F_HARD_FAULT = 4'h7,
        F_SAVING_TOGGLE = 4'h8,
        F_CURRENT_PULSE = 4'h9,
        F_SERVICE_DUE = 4'hA,
        F_HOST_SET = 4'hB,
        F_WARNING = 4'hC,
        F_FAULT = 4'hD
    } func_idx_t;
    localparam int NUM_FUNC = 14;
endpackage : outsel_pkg
`default_nettype wire

// ---- outsel_properties.sv ----
// outsel_properties.sv: port-level checks for the output terminal selector, with its bind.
// assumes the top module's ports and its POLE_CYCLES parameter.
`default_nettype none
module outsel_properties #(
    parameter int POLE_CYCLES = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // drive state
    input wire logic forward_start_cmd,
    input wire logic reverse_start_cmd,
    input wire logic output_stop_input,
    input wire logic [15:0] output_freq,
    input wire logic dc_brake_active,
    input wire logic trip_shutoff,
    input wire logic power_loss,
    input wire logic magnet_motor_mode_flag,
    input wire logic fault_flag,
    // status
    input wire logic drive_ready_flag,
    input wire logic running_flag
);
    logic [31:0] start_cnt_ff;
    logic [31:0] nxt_start_cnt;
    // raw pin run length, not shorter than the synchronised one while a raw start pin stays high
    assign nxt_start_cnt = (forward_start_cmd || reverse_start_cmd) ? start_cnt_ff + 32'h0000_0001 : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            start_cnt_ff <= '0;
        else
            start_cnt_ff <= nxt_start_cnt;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_apb_answer;
        psel && !penable |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no answer after setup");
    property p_trip_off;
        trip_shutoff |=> !drive_ready_flag && !running_flag;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("status on during trip");
    property p_fault_off;
        fault_flag |=> !drive_ready_flag;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("ready on during fault");
    property p_stop_off;
        output_stop_input [*3] |=> !drive_ready_flag && !running_flag;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("status on during stop input");
    property p_brake_off;
        dc_brake_active |=> !running_flag;
    endproperty
    a_brake_off: assert property (p_brake_off) else $error("running during brake");
    property p_loss_off;
        (!forward_start_cmd && !reverse_start_cmd) [*3] ##0 power_loss |=> !drive_ready_flag;
    endproperty
    a_loss_off: assert property (p_loss_off) else $error("ready on during power loss");
    property p_magnet_thr;
        magnet_motor_mode_flag && output_freq == 16'h0000 |=> !running_flag;
    endproperty
    a_magnet_thr: assert property (p_magnet_thr) else $error("running below magnet threshold");
    property p_pole_wait;
        $rose(running_flag) && magnet_motor_mode_flag |-> start_cnt_ff >= POLE_CYCLES;
    endproperty
    a_pole_wait: assert property (p_pole_wait) else $error("running before pole detection");
endmodule : outsel_properties
bind output_terminal_function_select outsel_properties #(.POLE_CYCLES(POLE_CYCLES)) i_outsel_properties (
    .pclk, .presetn, .psel, .penable, .pready, .forward_start_cmd, .reverse_start_cmd, .output_stop_input,
    .output_freq, .dc_brake_active, .trip_shutoff, .power_loss, .magnet_motor_mode_flag, .fault_flag,
    .drive_ready_flag, .running_flag);
`default_nettype wire

// ---- pin_sync.sv ----
// pin_sync.sv: two-flop synchroniser, one chain per bit.
// assumes asynchronous inputs and an active-low asynchronous reset.
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bits
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_ff;
            logic hold_ff;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[i];
                    hold_ff <= meta_ff;
                end
            end
            assign sync_out[i] = hold_ff;
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// ---- term_mux.sv ----
// term_mux.sv: one programmable output terminal: function pick, then polarity.
// assumes flags are synchronous to pclk; out is registered.
`default_nettype none
`include "outsel_consts.svh"
module term_mux #(
    parameter bit IS_RELAY = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // selection and sources
    input wire logic [7:0] sel_code,
    input wire logic [outsel_pkg::NUM_FUNC-1:0] flags,
    // terminal drive, high = conducting
    output logic term_out
);
    logic neg;
    logic [7:0] base;
    logic [3:0] idx;
    logic hit;
    logic nxt_out;
    logic out_ff;

    assign neg = (sel_code >= `CODE_NEG_BASE) && (sel_code <= `CODE_MAX);
    assign base = neg ? (sel_code - `CODE_NEG_BASE) : sel_code;

    always_comb begin
        idx = 4'h0;
        hit = 1'b1;
        case (base)
            `CODE_RUNNING: idx = outsel_pkg::F_RUNNING;
            `CODE_READY: idx = outsel_pkg::F_READY;
            `CODE_MAGNET: idx = outsel_pkg::F_MAGNET;
            `CODE_RETRY: idx = outsel_pkg::F_RETRY;
            `CODE_PID_PAUSE: idx = outsel_pkg::F_PID_PAUSE;
            `CODE_ENERGY_PULSE: idx = outsel_pkg::F_ENERGY_PULSE;
            `CODE_WEAR: idx = outsel_pkg::F_WEAR;
            `CODE_HARD_FAULT: idx = outsel_pkg::F_HARD_FAULT;
            `CODE_SAVING_TOGGLE: begin
                idx = outsel_pkg::F_SAVING_TOGGLE;
                hit = !IS_RELAY;
            end
            `CODE_CURRENT_PULSE: begin
                idx = outsel_pkg::F_CURRENT_PULSE;
                hit = !IS_RELAY;
            end
            `CODE_SERVICE_DUE: idx = outsel_pkg::F_SERVICE_DUE;
            `CODE_HOST_SET: idx = outsel_pkg::F_HOST_SET;
            `CODE_WARNING: idx = outsel_pkg::F_WARNING;
            `CODE_FAULT: idx = outsel_pkg::F_FAULT;
            default: hit = 1'b0;
        endcase
        if (sel_code > `CODE_MAX) begin
            hit = 1'b0;
        end
    end

    // polarity after selection
    assign nxt_out = hit & (flags[idx] ^ neg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
        end
    end
    assign term_out = out_ff;
endmodule : term_mux
`default_nettype wire

// ---- terminal_load.sv ----
// terminal_load.sv: equipment wired to the two terminals.
// assumes a pull-up on the open-collector line and a contact on the relay.
`default_nettype none
module terminal_load (
    // terminal drive
    input wire logic term_a_out,
    input wire logic term_b_out,
    // what the equipment sees
    output logic a_line,
    output logic b_contact
);
    // pulled high unless the terminal conducts
    assign a_line = !term_a_out;
    assign b_contact = term_b_out;
endmodule : terminal_load
`default_nettype wire
